// File: logic/tpd_deframer.sv
// Tunnel packet deframer: pulls tunneled IP packets out of fixed-size
// RTP tunnel packets, one byte per clock, into a 16-word output FIFO.
// Assumes one tunnel stream (one port), already in sequence order.
//
// Summary of operation
// R1: Every tunnel packet has one fixed size: header then payload.
// R2: Producer sets marker on packets whose payload holds a packet start.
// R3: Start pointer counts bytes from RTP header end to first start.
// R4: Start pointer is used only when the marker bit is set.
// R5: Producer points only at the earliest start in a payload.
// R6: Later starts are found by walking each tunneled length field.
// R7: Walked start position is checked against the start pointer.
// R8: Middle-only segments travel with the marker bit clear.
// R9: Bytes before a nonzero pointer continue the incomplete packet.
// R10: A length past the payload end continues in the next packet.
// R11: Producer packs packets and segments back to back.
// R12: Producer may preset constant header fields in its buffers.
// R13: From any point, lock on the next marked packet's pointer.
// R14: Producer writes pointer zero when a start follows the header.
// R15: Only tunnel packets with payload type 97 are accepted.
// R16: Sequence number steps by one modulo 65536 per packet.
// R17: On a sequence gap drop the partial packet; wait for a marker. Code keeps bytes already out, drops the rest, flags err on the next sop.
module tpd_deframer
    import tpd_pkg::*;
#(
    parameter int PKT_BYTES = 1024,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Tunnel byte stream in
    input wire logic in_valid_i,
    input wire logic in_sop_i,
    input wire logic [DATA_W-1:0] in_data_i,
    output logic in_ready_o,
    // Tunneled packet bytes out
    output logic out_valid_o,
    output logic [DATA_W-1:0] out_data_o,
    output logic out_sop_o,
    output logic out_eop_o,
    output logic out_err_o,
    input wire logic out_ready_i,
    // Status
    output logic synced_o,
    output logic seq_gap_o,
    output logic enc_err_o
);

    if (PKT_BYTES <= 16 || PKT_BYTES > 65535) begin : g_bad_size
        $error("PKT_BYTES must lie between 17 and 65535");
    end

    localparam logic [15:0] PKT_LAST = 16'(PKT_BYTES - 1);
    localparam logic [31:0] PAY_BYTES = 32'(PKT_BYTES) - 32'(RTP_HDR_BYTES);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [15:0] pos;
        logic mark;
        logic pt_ok;
        logic skip;
        logic use_mark;
        logic [7:0] seq_hi;
        logic seq_have;
        logic [15:0] seq_exp;
        logic [31:0] off;
        logic synced;
        logic [15:0] rem;
        logic [1:0] hidx;
        logic [7:0] len_hi;
        logic err_pend;
        logic in_rdy;
        logic o_vld;
        logic [OUT_W-1:0] o_word;
        logic gap;
        logic enc_err;
    } tpd_state_t;

    tpd_state_t q, d;
    tpd_fifo_if #(.W(OUT_W)) ff_if ();

    logic emit;
    logic e_sop;
    logic e_eop;
    logic err_now;
    logic busy;
    logic at_off;
    logic before_off;
    logic [15:0] cur;
    logic [15:0] p;
    logic [15:0] seq;
    logic [15:0] len;
    logic [31:0] off_new;

    tpd_fifo #(
        .WIDTH(OUT_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .ff(ff_if.store)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d = q;
        d.gap = 1'b0;
        d.enc_err = 1'b0;
        emit = 1'b0;
        e_sop = 1'b0;
        e_eop = 1'b0;
        err_now = 1'b0;
        cur = in_sop_i ? '0 : q.pos;
        p = cur - RTP_HDR_BYTES;
        seq = {q.seq_hi, in_data_i};
        len = {q.len_hi, in_data_i};
        off_new = {q.off[23:0], in_data_i};
        busy = (q.rem != '0) || (q.hidx != '0);
        // Pointer relative to header end, honoured only under marker
        at_off = q.use_mark && (p == q.off[15:0]); // R3 R4
        before_off = q.use_mark && (p < q.off[15:0]);

        // One-word output stage keeps the output ports on flip-flops
        ff_if.pop_ready = !q.o_vld || out_ready_i;
        if (ff_if.pop_valid && ff_if.pop_ready) begin
            d.o_vld = 1'b1;
            d.o_word = ff_if.pop_data;
        end else if (out_ready_i) begin
            d.o_vld = 1'b0;
        end
        // Two-entry margin covers the one-cycle lag of the registered ready
        d.in_rdy = !ff_if.afull;

        if (in_valid_i && q.in_rdy) begin
            d.pos = (cur == PKT_LAST) ? '0 : cur + 16'h0001; // R1
            if (cur < RTP_HDR_BYTES) begin
                if (cur == RTP_B_MPT) begin
                    d.mark = in_data_i[MARK_BIT];
                    d.pt_ok = (in_data_i[6:0] == PT_TUNNEL); // R15
                end
                if (cur == RTP_B_SEQ_HI) begin
                    d.seq_hi = in_data_i;
                end
                if (cur == RTP_B_SEQ_LO && q.pt_ok) begin
                    if (q.seq_have && seq != q.seq_exp) begin // R16
                        d.gap = 1'b1;
                        d.synced = 1'b0; // R17
                        d.rem = '0;
                        d.hidx = '0;
                        d.err_pend = q.err_pend || (q.synced && busy);
                    end
                    d.seq_have = 1'b1;
                    d.seq_exp = seq + SEQ_STEP;
                end
                if (cur >= RTP_B_OFF0) begin
                    d.off = off_new;
                end
                if (cur == RTP_HDR_BYTES - 16'h0001) begin
                    d.skip = !q.pt_ok; // R15
                    d.use_mark = q.pt_ok && q.mark // R4
                        && (off_new < PAY_BYTES);
                    if (q.pt_ok && q.mark && off_new >= PAY_BYTES) begin
                        d.enc_err = 1'b1;
                    end
                end
            end else if (!q.skip) begin
                if (at_off) begin
                    // Walked position must agree with the pointer
                    if (q.synced && busy) begin // R7
                        d.enc_err = 1'b1;
                        err_now = 1'b1;
                    end
                    emit = 1'b1; // R13
                    e_sop = 1'b1;
                    d.synced = 1'b1;
                    d.rem = '0;
                    d.hidx = 2'h1;
                end else if (q.synced) begin
                    if (!busy) begin
                        if (before_off) begin
                            // A walked start ahead of the pointer is false
                            d.enc_err = 1'b1; // R7
                            d.synced = 1'b0;
                        end else begin
                            emit = 1'b1; // R6
                            e_sop = 1'b1;
                            d.hidx = 2'h1;
                        end
                    end else if (q.hidx != '0) begin
                        emit = 1'b1;
                        d.hidx = q.hidx + 2'h1;
                        if (q.hidx == HIDX_LEN_HI) begin
                            d.len_hi = in_data_i;
                        end
                        if (q.hidx == HIDX_LEN_LO) begin
                            if (len < IP_LEN_MIN) begin
                                d.enc_err = 1'b1;
                                d.synced = 1'b0;
                                d.err_pend = 1'b1;
                                d.rem = '0;
                            end else begin
                                d.rem = len - IP_LEN_PEEK; // R6 R10
                            end
                        end
                    end else begin
                        // Body bytes, also those ahead of a nonzero pointer
                        emit = 1'b1; // R9 R10
                        d.rem = q.rem - 16'h0001;
                        e_eop = (q.rem == 16'h0001);
                    end
                end
            end
        end

        // A start carries err when the packet before it was cut short
        if (e_sop) begin
            err_now = err_now || q.err_pend;
            d.err_pend = 1'b0;
        end
        ff_if.push_valid = emit;
        ff_if.push_data = {err_now, e_eop, e_sop, in_data_i};
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign in_ready_o = q.in_rdy;
    assign out_valid_o = q.o_vld;
    assign out_data_o = q.o_word[DATA_W-1:0];
    assign out_sop_o = q.o_word[W_SOP];
    assign out_eop_o = q.o_word[W_EOP];
    assign out_err_o = q.o_word[W_ERR];
    assign synced_o = q.synced;
    assign seq_gap_o = q.gap;
    assign enc_err_o = q.enc_err;

endmodule : tpd_deframer

// File: logic/tpd_fifo.sv
// Synchronous FIFO for extracted bytes, valid/ready on both sides.
// Assumes one clock; afull warns two entries ahead of full.
module tpd_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Queue ports
    tpd_fifo_if.store ff
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two, at least 4");
    end

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tpd_fifo_st_t;

    tpd_fifo_st_t q, d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_push;
    logic do_pop;

    assign ff.push_ready = (q.cnt != (AW+1)'(DEPTH));
    assign ff.pop_valid = (q.cnt != '0);
    assign ff.pop_data = mem[q.rp];
    assign ff.afull = (q.cnt >= (AW+1)'(DEPTH - 2));
    assign do_push = ff.push_valid && ff.push_ready;
    assign do_pop = ff.pop_ready && ff.pop_valid;

    always_comb begin
        d = q;
        if (do_push) begin
            d.wp = q.wp + 1'b1;
        end
        if (do_pop) begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Storage has no reset: contents are only read behind a valid count
    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem[q.wp] <= ff.push_data;
        end
    end

endmodule : tpd_fifo

// File: pkg/tpd_fifo_if.sv
// Carrier between the deframer and its output FIFO.
// Assumes both ends share one clock; the interface itself holds no state.
interface tpd_fifo_if #(
    parameter int W = 11
);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    logic afull;

    modport fill (
        output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data, afull
    );
    modport store (
        input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data, afull
    );
endinterface : tpd_fifo_if

// File: pkg/tpd_pkg.sv
// Constants shared by the tunnel packet deframer and its output FIFO.
// Assumes RTP tunnel packets arrive byte-wide, header first.
package tpd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Tunnel RTP header layout, byte indices from the first header byte
    localparam logic [15:0] RTP_HDR_BYTES = 16'h000C;
    localparam logic [15:0] RTP_B_MPT = 16'h0001;
    localparam logic [15:0] RTP_B_SEQ_HI = 16'h0002;
    localparam logic [15:0] RTP_B_SEQ_LO = 16'h0003;
    localparam logic [15:0] RTP_B_OFF0 = 16'h0008;
    localparam int MARK_BIT = 7;
    localparam logic [6:0] PT_TUNNEL = 7'h61;
    localparam logic [15:0] SEQ_STEP = 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Tunneled IP header: total length sits in bytes 2 and 3
    localparam logic [1:0] HIDX_LEN_HI = 2'h2;
    localparam logic [1:0] HIDX_LEN_LO = 2'h3;
    localparam logic [15:0] IP_LEN_PEEK = 16'h0004;
    localparam logic [15:0] IP_LEN_MIN = 16'h0014;

    ////////////////////////////////////////////////////////////////////////
    // Output word: {err, eop, sop, data}
    localparam int DATA_W = 8;
    localparam int OUT_W = 11;
    localparam int W_SOP = 8;
    localparam int W_EOP = 9;
    localparam int W_ERR = 10;
    localparam int FIFO_DEPTH = 16;

endpackage : tpd_pkg

// File: testbench/testbench.sv
// Self-checking bench for the tunnel packet deframer.
// Assumes the producer model and 64-byte tunnel packets.
module testbench
    import tpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int N = 64;
    localparam int PAY = N - 12;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic rdy = 1'b0;
    logic hold = 1'b0;
    logic refused = 1'b0;
    logic iv, is, ir, ov, os, oe, oerr, synced, gap, enc, busy;
    logic [7:0] id, od;
    logic [7:0] pkt [N];
    logic [7:0] strm [$];
    logic [OUT_W-1:0] expq [$];
    logic [OUT_W-1:0] seen;
    int seed = 93810;
    int num_errors = 0;
    int comparisons = 0;
    int gaps = 0;
    int encs = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    tpd_producer #(.N(N)) prod_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .go_i(go), .slow_i(slow), .pkt_i(pkt), .ready_i(ir), .busy_o(busy),
        .valid_o(iv), .sop_o(is), .data_o(id));
    tpd_deframer #(.PKT_BYTES(N)) dut_u (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .in_valid_i(iv), .in_sop_i(is), .in_data_i(id),
        .in_ready_o(ir), .out_valid_o(ov), .out_data_o(od), .out_sop_o(os),
        .out_eop_o(oe), .out_err_o(oerr), .out_ready_i(rdy),
        .synced_o(synced), .seq_gap_o(gap), .enc_err_o(enc));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [OUT_W-1:0] mk_word(logic e, logic eo, logic so,
                                                 logic [7:0] d);
        return {e, eo, so, d};
    endfunction : mk_word
    task automatic chk_word(string what, logic [OUT_W-1:0] e,
                            logic [OUT_W-1:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(string what, logic e, logic g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit
    task automatic summarize();
        $display("Comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    // One tunneled packet: length in bytes 2 and 3, random body
    task automatic mk_ip(int len, logic err);
        logic [7:0] b;
        for (int i = 0; i < len; i++) begin
            b = 8'($random(seed));
            if (i == 2) b = 8'(len >> 8);
            if (i == 3) b = 8'(len);
            strm.push_back(b);
            expq.push_back(mk_word(err && i == 0, i == len - 1, i == 0, b));
        end
    endtask : mk_ip
    // One tunnel packet; base < 0 gives a random payload
    task automatic tun(logic m, logic [6:0] pt, logic [15:0] sq,
                       logic [31:0] ptr, int base);
        int k;
        pkt[0] = 8'h80;
        pkt[1] = {m, pt};
        {pkt[2], pkt[3]} = sq;
        for (k = 4; k < 8; k++) pkt[k] = 8'($random(seed));
        {pkt[8], pkt[9], pkt[10], pkt[11]} = ptr;
        for (k = 0; k < PAY; k++)
            pkt[12 + k] = (base < 0) ? 8'($random(seed)) : strm[base + k];
        @(posedge clk_sys_i);
        #2 go = 1'b1;
        @(posedge clk_sys_i);
        #2 go = 1'b0;
        // Busy moves at the same offset as go, so look one edge later
        @(posedge clk_sys_i);
        for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk_sys_i);
        if (k == 3000) begin
            num_errors++;
            summarize();
        end
        repeat (4) @(posedge clk_sys_i);
    endtask : tun
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        #2 rdy = !hold && ($random(seed) % 4) != 0;
        slow = ($random(seed) % 8) == 0;
    end
    always @(posedge clk_sys_i) begin
        if (ov === 1'b1 && rdy === 1'b1) begin
            seen = {oerr, oe, os, od};
            if (expq.size() == 0) chk_bit("spare output", 1'b0, 1'b1);
            else chk_word("output word", expq.pop_front(), seen);
        end
        if (gap === 1'b1) gaps++;
        if (enc === 1'b1) encs++;
        if (hold && ir === 1'b0 && busy === 1'b1) refused = 1'b1;
    end
    initial begin
        for (int i = 0; i < N; i++) pkt[i] = 8'h00;
        repeat (2) @(posedge clk_sys_i);
        #2 resetn_i = 1'b1;
        tun(1'b0, PT_TUNNEL, 16'hFFFE, 32'h0000_0000, -1);
        chk_bit("synced before marker", 1'b0, synced);
        mk_ip(20, 1'b0);
        mk_ip(40, 1'b0);
        mk_ip(50, 1'b0);
        hold = 1'b1;
        fork
            begin
                repeat (150) @(posedge clk_sys_i);
                #2 hold = 1'b0;
            end
        join_none
        tun(1'b1, PT_TUNNEL, 16'hFFFF, 32'h0000_0000, 0);
        chk_bit("input refused when full", 1'b1, refused);
        chk_bit("synced after marker", 1'b1, synced);
        tun(1'b1, PT_TUNNEL, 16'h0000, 32'h0000_0008, PAY);
        // Tail of the open packet is never sent
        repeat (6) void'(expq.pop_back());
        tun(1'b0, PT_TUNNEL, 16'h0002, 32'h0000_0000, -1);
        chk_bit("synced after gap", 1'b0, synced);
        tun(1'b1, 7'h60, 16'h0003, 32'h0000_0000, -1);
        strm.delete();
        mk_ip(PAY, 1'b1);
        tun(1'b1, PT_TUNNEL, 16'h0003, 32'h0000_0000, 0);
        // One packet over three tunnel packets, the middle one unmarked
        strm.delete();
        mk_ip(120, 1'b0);
        mk_ip(36, 1'b0);
        tun(1'b1, PT_TUNNEL, 16'h0004, 32'h0000_0000, 0);
        // Stale pointer in an unmarked packet must be ignored
        tun(1'b0, PT_TUNNEL, 16'h0005, 32'h0000_0005, PAY);
        tun(1'b1, PT_TUNNEL, 16'h0006, 32'h0000_0010, 2 * PAY);
        chk_bit("no framing error", 1'b1, encs == 0);
        // Pointer ahead of the walk: the pointer wins and lock is redone
        strm.delete();
        repeat (4) strm.push_back(8'h00);
        mk_ip(48, 1'b0);
        tun(1'b1, PT_TUNNEL, 16'h0007, 32'h0000_0004, 0);
        chk_bit("synced after pointer", 1'b1, synced);
        for (int k = 0; k < 500 && expq.size() != 0; k++) @(posedge clk_sys_i);
        chk_bit("all words out", 1'b1, expq.size() == 0);
        chk_bit("one gap pulse", 1'b1, gaps == 1);
        chk_bit("one framing error", 1'b1, encs == 1);
        summarize();
    end
endmodule : testbench

// File: testbench/tpd_deframer_assertions.sv
// Port checks for the tunnel packet deframer.
// Assumes one clock; bound to every deframer instance.
module tpd_deframer_assertions
    import tpd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Input stream
    input wire logic in_valid_i,
    input wire logic in_sop_i,
    input wire logic [DATA_W-1:0] in_data_i,
    input wire logic in_ready_o,
    // Output stream
    input wire logic out_valid_o,
    input wire logic [DATA_W-1:0] out_data_o,
    input wire logic out_sop_o,
    input wire logic out_eop_o,
    input wire logic out_err_o,
    input wire logic out_ready_i,
    // Status
    input wire logic synced_o,
    input wire logic seq_gap_o,
    input wire logic enc_err_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Open packet seen on the output, survives gaps until a flagged sop
    logic open_q;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            open_q <= 1'b0;
        end else if (out_valid_o && out_ready_i) begin
            open_q <= !out_eop_o;
        end
    end
    sequence s_take;
        out_valid_o && out_ready_i;
    endsequence
    sequence s_stall;
        out_valid_o && !out_ready_i;
    endsequence
    a_out_hold: assert property (s_stall |=> out_valid_o
        && $stable({out_data_o, out_sop_o, out_eop_o, out_err_o}))
        else $error("output word changed while stalled");
    a_mid_in_pkt: assert property (s_take ##0 !out_sop_o |-> open_q)
        else $error("byte outside a tunneled packet");
    a_cut_flagged: assert property (s_take ##0 (out_sop_o && open_q)
        |-> out_err_o) else $error("cut packet not flagged");
    a_err_on_sop: assert property (out_valid_o && out_err_o
        |-> out_sop_o) else $error("error flag away from sop");
    a_gap_pulse: assert property (seq_gap_o |=> !seq_gap_o)
        else $error("gap flag longer than one cycle");
    a_enc_pulse: assert property (enc_err_o |=> !enc_err_o)
        else $error("framing error flag too long");
    a_gap_unsync: assert property (seq_gap_o |-> ##[0:1] !synced_o)
        else $error("still locked after a gap");
    a_lock_on_byte: assert property ($rose(synced_o)
        |-> $past(in_valid_i && in_ready_o))
        else $error("lock without a byte taken");
endmodule : tpd_deframer_assertions

bind tpd_deframer tpd_deframer_assertions chk_u (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .in_valid_i(in_valid_i), .in_sop_i(in_sop_i),
    .in_data_i(in_data_i), .in_ready_o(in_ready_o),
    .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_sop_o(out_sop_o), .out_eop_o(out_eop_o), .out_err_o(out_err_o),
    .out_ready_i(out_ready_i), .synced_o(synced_o),
    .seq_gap_o(seq_gap_o), .enc_err_o(enc_err_o));

// File: testbench/tpd_producer.sv
// Studio-side producer model: sends one whole tunnel packet per go.
// Assumes the bench fills pkt_i while the model is idle.
module tpd_producer #(
    parameter int N = 64
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic go_i,
    input wire logic slow_i,
    input wire logic [7:0] pkt_i [N],
    input wire logic ready_i,
    output logic busy_o = 1'b0,
    output logic valid_o = 1'b0,
    output logic sop_o = 1'b0,
    output logic [7:0] data_o = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    int idx = 0;
    int nxt;
    logic rst;
    logic start;
    logic take;
    logic pause;
    // Bytes go back to back unless slowed; idle data toggles, but holds in reset and on the go cycle
    // Inputs are sampled on the edge, outputs move a little after it
    always @(posedge clk_sys_i) begin
        rst = !resetn_i;
        start = go_i && !busy_o;
        take = valid_o && ready_i;
        pause = slow_i;
        #2;
        if (rst) begin
            busy_o = 1'b0;
            valid_o = 1'b0;
            sop_o = 1'b0;
        end else if (start) begin
            busy_o = 1'b1;
            idx = 0;
        end else if (!valid_o || take) begin
            nxt = take ? idx + 1 : idx;
            idx = nxt;
            if (busy_o && nxt < N && !pause) begin
                valid_o = 1'b1;
                sop_o = (nxt == 0);
                data_o = pkt_i[nxt];
            end else begin
                valid_o = 1'b0;
                sop_o = 1'b0;
                data_o = ~data_o;
            end
            if (nxt >= N) busy_o = 1'b0;
        end
    end
endmodule : tpd_producer
